// file: logic/gpio_function_control_params.svh
/*
 Address map, field positions, reset values and timing counts of the
 pin function block. Assumes inclusion by bare name from design files.
*/
`ifndef GPIO_FUNCTION_CONTROL_PARAMS_SVH
`define GPIO_FUNCTION_CONTROL_PARAMS_SVH
// register addresses on the serial register port
`define STATUS_ADDR 8'h23
`define PIN_CFG_ADDR 8'h24
`define MODE_ADDR 8'h25
// power-management bus page and command codes
`define PM_PAGE 8'hFF
`define PM_STATUS_CMD 8'hE7
`define PM_PIN_CFG_CMD 8'hE8
`define PM_MODE_CMD 8'hE9
// reset values
`define PIN_CFG_RESET 16'h0000
`define MODE_RESET 16'h0000
// pin function settings fields
`define FILTER_ON_BIT 15
`define OUT_ON_BIT 13
`define OUT_SRC_HI 12
`define OUT_SRC_LO 9
`define CH_MASK_HI 8
`define CH_MASK_LO 5
`define IN_FUNC_HI 4
`define IN_FUNC_LO 1
`define IN_ON_BIT 0
// channel mask bits inside the four-bit field
`define MASK_CH1_BIT 0
`define MASK_CH0_BIT 3
// operating mode settings fields
`define LOW_POWER_BIT 13
`define SHUTDOWN_HI 9
`define SHUTDOWN_LO 8
// status word fields
`define FLAG_BIT 8
`define WC0_BIT 7
`define WC1_BIT 4
// clock and glitch filter timing
`define CLK_PERIOD_NS 100
`define GLITCH_NS 400
`define GLITCH_CYCLES ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: logic/gpio_function_control_pkg.sv
/*
 Types of the pin function block: input functions, output sources,
 shutdown behaviours and the shutdown sequencer states.
 Assumes nothing of its surroundings.
*/
package gpio_function_control_pkg;
   // input actions selected by the input function field
   typedef enum logic [3:0] {
      FN_FAULT_DUMP = 4'h2,
      FN_CUR_PD = 4'h3,
      FN_VOLT_PD = 4'h4,
      FN_SHUTDOWN = 4'h5,
      FN_CLEAR = 4'h7,
      FN_SYNC_LOAD = 4'h8,
      FN_WAVE = 4'h9,
      FN_MARGIN = 4'hA,
      FN_RESET = 4'hB,
      FN_NVM_PROT = 4'hC,
      FN_MAP_LOCK = 4'hD
   } in_func_t;
   // status bits that may drive the pin
   typedef enum logic [3:0] {
      SRC_MEM_BUSY = 4'h1,
      SRC_CH1_BUSY = 4'h4,
      SRC_CH0_BUSY = 4'h7,
      SRC_WC1 = 4'h8,
      SRC_WC0 = 4'hB
   } out_src_t;
   // shutdown behaviour choices
   typedef enum logic [1:0] {
      SHD_HIZ = 2'h0,
      SHD_STORED = 2'h1,
      SHD_LOW = 2'h2,
      SHD_HIGH = 2'h3
   } shutdown_t;
   // shutdown sequencer, one-hot
   typedef enum logic [3:0] {
      SQ_IDLE = 4'h1,
      SQ_LOAD = 4'h2,
      SQ_SLEW = 4'h4,
      SQ_HIZ = 4'h8
   } seq_state_t;
endpackage

// file: logic/pin_event_if.sv
/*
 Carrier of the conditioned pin level and its edge pulses between the
 input conditioner and the function controller. One clock domain.
*/
`timescale 1ns/10ps
interface pin_event_if;
   logic level; // conditioned pin level
   logic rise; // one-cycle rising edge pulse
   logic fall; // one-cycle falling edge pulse
   // producer side
   modport cond (output level, rise, fall);
   // consumer side
   modport user (input level, rise, fall);
endinterface // pin_event_if

// file: logic/pin_input_conditioner.sv
/*
 Synchroniser, optional glitch filter and edge detector for the pin.
 Assumes pin_raw is asynchronous to clk and filter_on is on clk.
*/
`timescale 1ns/10ps
`include "gpio_function_control_params.svh"
module pin_input_conditioner #(
   parameter int FILTER_CYCLES = `GLITCH_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // pin and control
   input wire logic pin_raw,
   input wire logic filter_on,
   // conditioned events
   pin_event_if.cond ev
);
   logic sync_a; // first synchroniser stage
   logic sync_b; // second synchroniser stage
   logic cand; // last raw sample seen by the filter
   logic [7:0] stable_cnt; // cycles cand has been stable
   logic level; // conditioned level
   logic prev; // previous conditioned level
   logic next_level; // conditioned level next cycle

   ////////////////////////////////////////////////////////////////////
   // two-stage synchroniser, idle high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else begin
         sync_a <= pin_raw;
         sync_b <= sync_a;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // stability counter of the glitch filter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cand <= 1'b1;
         stable_cnt <= 8'h00;
      end else if (sync_b != cand) begin
         cand <= sync_b;
         stable_cnt <= 8'h00;
      end else if (stable_cnt != 8'hFF) begin
         stable_cnt <= stable_cnt + 8'h01;
      end
   end

   // filtered path waits for a stable run, bypass follows directly
   always_comb begin
      next_level = level;
      if (!filter_on) begin
         next_level = sync_b;
      end else if (stable_cnt >= 8'(FILTER_CYCLES - 1)) begin
         next_level = cand;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // level and previous sample for edge detection
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level <= 1'b1;
         prev <= 1'b1;
      end else begin
         level <= next_level;
         prev <= level;
      end
   end

   // edges compare current sample with previous one
   assign ev.level = level;
   assign ev.rise = level & ~prev;
   assign ev.fall = ~level & prev;
endmodule // pin_input_conditioner

// file: logic/gpio_function_control.sv
/*
 Multi-function general-purpose pin of a dual-channel converter: the
 pin settings and operating mode registers, status output mux, input
 actions and the safe-shutdown sequencer.
 Assumes register and power-bus accesses arrive as one-cycle strobes on
 ref_clk, and status inputs come from logic on ref_clk.
*/
`timescale 1ns/10ps
`include "gpio_function_control_params.svh"
module gpio_function_control
   import gpio_function_control_pkg::*;
#(
   parameter int FILTER_CYCLES = `GLITCH_CYCLES,
   parameter int CHANNELS = 2
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // serial register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // power-management bus port
   input wire logic pm_wr,
   input wire logic pm_rd,
   input wire logic [7:0] pm_page,
   input wire logic [7:0] pm_cmd,
   // general-purpose pin
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   // status sources
   input wire logic memory_write_pending,
   input wire logic ch0_busy,
   input wire logic ch1_busy,
   input wire logic window_compare_ch0,
   input wire logic window_compare_ch1,
   input wire logic slew_done,
   // global actions
   output logic fault_dump,
   output logic output_clear,
   output logic device_reset,
   output logic nvm_write_allow,
   output logic map_locked,
   // per-channel actions, index 0 is channel 0
   output logic [CHANNELS-1:0] current_output_down,
   output logic [CHANNELS-1:0] voltage_output_down,
   output logic [CHANNELS-1:0] synchronous_load,
   output logic [CHANNELS-1:0] wave_run,
   output logic [CHANNELS-1:0] margin_high,
   // shutdown sequencer and mode outputs
   output logic shutdown_load_stored,
   output logic shutdown_slew_low,
   output logic shutdown_slew_high,
   output logic shutdown_hiz,
   output logic low_power_select,
   output logic shutdown_flag
);
   logic [15:0] pin_cfg; // pin function settings
   logic [15:0] mode_cfg; // operating mode settings
   pin_event_if ev (); // conditioned pin events
   logic pm_hit; // power bus addresses this page
   logic wr_cfg; // accepted write to pin settings
   logic wr_mode; // accepted write to mode settings
   logic rd_status; // read of the status word
   logic [7:0] rd_addr; // address of the current read
   logic in_on; // input actions enabled
   logic [3:0] func; // raw input function field
   logic [3:0] mask; // raw channel mask field
   logic [CHANNELS-1:0] chan_sel; // channel enables by index
   logic act_rise; // qualified rising edge
   logic act_fall; // qualified falling edge
   logic func_valid; // function code is a listed one
   logic shutdown_go; // start of safe shutdown
   logic next_out; // next pin output value
   seq_state_t seq; // shutdown sequencer state
   seq_state_t next_seq; // its next value

   ////////////////////////////////////////////////////////////////////
   // pin conditioning
   pin_input_conditioner #(.FILTER_CYCLES(FILTER_CYCLES)) u_cond (
      .clk(ref_clk),
      .resetn(resetn),
      .pin_raw(pin_in),
      .filter_on(pin_cfg[`FILTER_ON_BIT]),
      .ev(ev)
   );

   ////////////////////////////////////////////////////////////////////
   // address decode, both ports share the registers
   assign pm_hit = (pm_page == `PM_PAGE);
   assign wr_cfg = ~map_locked & ((reg_wr & (reg_addr == `PIN_CFG_ADDR))
                   | (pm_wr & pm_hit & (pm_cmd == `PM_PIN_CFG_CMD)));
   assign wr_mode = ~map_locked & ((reg_wr & (reg_addr == `MODE_ADDR))
                    | (pm_wr & pm_hit & (pm_cmd == `PM_MODE_CMD)));
   // power bus commands map onto register addresses for reading
   always_comb begin
      rd_addr = 8'h00;
      if (reg_rd) begin
         rd_addr = reg_addr;
      end else if (pm_rd & pm_hit) begin
         unique case (pm_cmd)
            `PM_STATUS_CMD: rd_addr = `STATUS_ADDR;
            `PM_PIN_CFG_CMD: rd_addr = `PIN_CFG_ADDR;
            `PM_MODE_CMD: rd_addr = `MODE_ADDR;
            default: rd_addr = 8'h00; // unmapped command
         endcase
      end
   end
   assign rd_status = (reg_rd | (pm_rd & pm_hit)) & (rd_addr == `STATUS_ADDR);

   ////////////////////////////////////////////////////////////////////
   // pin function settings register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pin_cfg <= `PIN_CFG_RESET;
      end else if (wr_cfg) begin
         pin_cfg <= reg_wdata;
      end
   end

   // operating mode settings register, reserved bits kept as written
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_cfg <= `MODE_RESET;
      end else if (wr_mode) begin
         mode_cfg <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data, one cycle after the read strobe
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd | pm_rd) begin
         unique case (rd_addr)
            `PIN_CFG_ADDR: reg_rdata <= pin_cfg;
            `MODE_ADDR: reg_rdata <= mode_cfg;
            `STATUS_ADDR: begin
               reg_rdata <= 16'h0000;
               reg_rdata[`FLAG_BIT] <= shutdown_flag;
               reg_rdata[`WC0_BIT] <= window_compare_ch0;
               reg_rdata[`WC1_BIT] <= window_compare_ch1;
            end
            default: reg_rdata <= 16'h0000; // unmapped reads zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // field decode
   assign in_on = pin_cfg[`IN_ON_BIT];
   assign func = pin_cfg[`IN_FUNC_HI:`IN_FUNC_LO];
   assign mask = pin_cfg[`CH_MASK_HI:`CH_MASK_LO];
   assign chan_sel = {mask[`MASK_CH1_BIT], mask[`MASK_CH0_BIT]};
   // listed codes only
   always_comb begin
      unique case (func)
         FN_FAULT_DUMP, FN_CUR_PD, FN_VOLT_PD, FN_SHUTDOWN, FN_CLEAR,
         FN_SYNC_LOAD, FN_WAVE, FN_MARGIN, FN_RESET, FN_NVM_PROT,
         FN_MAP_LOCK: func_valid = 1'b1;
         default: func_valid = 1'b0;
      endcase
   end
   assign act_rise = in_on & func_valid & ev.rise;
   assign act_fall = in_on & func_valid & ev.fall;
   assign shutdown_go = act_fall & (func == FN_SHUTDOWN);

   ////////////////////////////////////////////////////////////////////
   // status output mux and driver enable
   always_comb begin
      unique case (pin_cfg[`OUT_SRC_HI:`OUT_SRC_LO])
         SRC_MEM_BUSY: next_out = memory_write_pending;
         SRC_CH1_BUSY: next_out = ch1_busy;
         SRC_CH0_BUSY: next_out = ch0_busy;
         SRC_WC1: next_out = window_compare_ch1;
         SRC_WC0: next_out = window_compare_ch0;
         default: next_out = 1'b0; // no source selected
      endcase
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= next_out;
         pin_oe <= pin_cfg[`OUT_ON_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // global pulse and level actions
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         fault_dump <= 1'b0;
         output_clear <= 1'b0;
      end else begin
         fault_dump <= act_fall & (func == FN_FAULT_DUMP);
         // held for as long as the pin stays low
         output_clear <= in_on & (func == FN_CLEAR) & ~ev.level;
      end
   end

   // global latched states set and cleared by edges
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         device_reset <= 1'b0;
         nvm_write_allow <= 1'b0;
         map_locked <= 1'b0;
      end else begin
         if (act_fall & (func == FN_RESET)) device_reset <= 1'b1;
         if (act_rise & (func == FN_RESET)) device_reset <= 1'b0;
         if (act_fall & (func == FN_NVM_PROT)) nvm_write_allow <= 1'b1;
         if (act_rise & (func == FN_NVM_PROT)) nvm_write_allow <= 1'b0;
         if (act_fall & (func == FN_MAP_LOCK)) map_locked <= 1'b0;
         if (act_rise & (func == FN_MAP_LOCK)) map_locked <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per-channel actions, only on channels the mask enables
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         current_output_down <= '0;
         voltage_output_down <= '0;
         synchronous_load <= '0;
         wave_run <= '0;
         margin_high <= '0;
      end else begin
         // load pulse on a falling edge, for the channels the mask enables
         synchronous_load <= (act_fall & (func == FN_SYNC_LOAD)) ? chan_sel : '0;
         for (int c = 0; c < CHANNELS; c++) begin
            if (chan_sel[c]) begin
               if (act_fall & (func == FN_CUR_PD)) current_output_down[c] <= 1'b1;
               if (act_rise & (func == FN_CUR_PD)) current_output_down[c] <= 1'b0;
               if (act_fall & (func == FN_VOLT_PD)) voltage_output_down[c] <= 1'b1;
               if (act_rise & (func == FN_VOLT_PD)) voltage_output_down[c] <= 1'b0;
               if (act_fall & (func == FN_WAVE)) wave_run[c] <= 1'b0;
               if (act_rise & (func == FN_WAVE)) wave_run[c] <= 1'b1;
               if (act_fall & (func == FN_MARGIN)) margin_high[c] <= 1'b0;
               if (act_rise & (func == FN_MARGIN)) margin_high[c] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // safe-shutdown sequencer
   always_comb begin
      next_seq = seq;
      unique case (seq)
         SQ_IDLE: begin
            if (shutdown_go) begin
               unique case (shutdown_t'(mode_cfg[`SHUTDOWN_HI:`SHUTDOWN_LO]))
                  SHD_HIZ: next_seq = SQ_HIZ;
                  SHD_STORED: next_seq = SQ_LOAD;
                  SHD_LOW, SHD_HIGH: next_seq = SQ_SLEW;
               endcase
            end
         end
         // stored code applied in one step
         SQ_LOAD: next_seq = SQ_HIZ;
         // wait for the channels to reach the margin code
         SQ_SLEW: begin
            if (slew_done) next_seq = SQ_HIZ;
         end
         // power-down reached, stays until a new trigger
         SQ_HIZ: begin
            if (shutdown_go) next_seq = SQ_IDLE;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         seq <= SQ_IDLE;
      end else begin
         seq <= next_seq;
      end
   end

   // sequencer outputs and mode bits
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         shutdown_load_stored <= 1'b0;
         shutdown_slew_low <= 1'b0;
         shutdown_slew_high <= 1'b0;
         shutdown_hiz <= 1'b0;
         low_power_select <= 1'b0;
      end else begin
         shutdown_load_stored <= (next_seq == SQ_LOAD);
         shutdown_slew_low <= (next_seq == SQ_SLEW) & ~mode_cfg[`SHUTDOWN_LO];
         shutdown_slew_high <= (next_seq == SQ_SLEW) & mode_cfg[`SHUTDOWN_LO];
         shutdown_hiz <= (next_seq == SQ_HIZ);
         low_power_select <= mode_cfg[`LOW_POWER_BIT];
      end
   end

   // shutdown flag, a new trigger wins over a clearing read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         shutdown_flag <= 1'b0;
      end else if (shutdown_go) begin
         shutdown_flag <= 1'b1;
      end else if (rd_status) begin
         shutdown_flag <= 1'b0;
      end
   end
endmodule // gpio_function_control

// file: tb/gpio_function_control_asserts.sv
/* checker of the pin function block ports
   assumes a bind to gpio_function_control, one ref_clk domain */
`timescale 1ns/10ps
module gpio_function_control_asserts #(
   parameter int CHANNELS = 2
) (
   // clock, reset and register port
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic pm_wr,
   input wire logic [7:0] pm_page,
   input wire logic [7:0] pm_cmd,
   // pin and status
   input wire logic pin_in,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic memory_write_pending,
   input wire logic ch0_busy,
   input wire logic ch1_busy,
   input wire logic window_compare_ch0,
   input wire logic window_compare_ch1,
   // actions
   input wire logic fault_dump,
   input wire logic output_clear,
   input wire logic map_locked,
   input wire logic [CHANNELS-1:0] synchronous_load
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic [15:0] cfg; // shadow of the pin settings
   logic sel; // status bit named by the source field
   logic listed; // source code is a listed one
   ////////////////////
   // shadow takes writes only while unlocked
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cfg <= 16'h0000;
      end else if (!map_locked && ((reg_wr && reg_addr == 8'h24) ||
                   (pm_wr && pm_page == 8'hFF && pm_cmd == 8'hE8))) begin
         cfg <= reg_wdata;
      end
   end
   // pick the status bit
   always_comb begin
      listed = 1'b1;
      case (cfg[12:9])
         4'h1: sel = memory_write_pending;
         4'h4: sel = ch1_busy;
         4'h7: sel = ch0_busy;
         4'h8: sel = window_compare_ch1;
         4'hB: sel = window_compare_ch0;
         default: begin
            sel = 1'b0;
            listed = 1'b0;
         end
      endcase
   end
   sequence s_cfg_rd;
      reg_rd && reg_addr == 8'h24 && !reg_wr && !pm_wr;
   endsequence
   sequence s_bad_rd;
      reg_rd && !(reg_addr inside {8'h23, 8'h24, 8'h25});
   endsequence
   sequence s_clr_high;
      (cfg[4:0] == 5'h0F && pin_in) [*8];
   endsequence
   a_dump_one_cycle: assert property (fault_dump |=> !fault_dump)
      else $error("fault dump wider than one cycle");
   a_dump_needs_cfg: assert property (fault_dump |-> cfg[4:0] == 5'h05)
      else $error("fault dump without its function");
   a_load_masked: assert property (|synchronous_load |-> cfg[4:0] == 5'h11 &&
      (synchronous_load & ~{cfg[5], cfg[8]}) == 2'b00) else $error("load on wrong channel");
   a_clear_needs_cfg: assert property (output_clear |-> cfg[4:0] == 5'h0F)
      else $error("clear without its function");
   a_clear_ends_high: assert property (s_clr_high |=> !output_clear)
      else $error("clear held with pin high");
   a_oe_follows_bit: assert property ($stable(cfg[13]) |-> pin_oe == cfg[13])
      else $error("pin drive enable wrong");
   a_out_follows_src: assert property (listed && $stable(sel) && $stable(cfg) |-> pin_out == sel)
      else $error("pin drive value wrong");
   a_cfg_read_back: assert property (s_cfg_rd |=> (reg_rdata & 16'hBFFF) == ($past(cfg) & 16'hBFFF))
      else $error("pin settings read wrong");
   a_unmapped_zero: assert property (s_bad_rd |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule // gpio_function_control_asserts

// file: tb/pin_host_model.sv
/* host side of the general-purpose pin
   assumes pin_oe is high while the device drives the pin */
`timescale 1ns/10ps
module pin_host_model (
   // device side
   input wire logic pin_out,
   input wire logic pin_oe,
   // level seen by the device
   output logic pin_in
);
   logic drv = 1'b1; // host level, idles high
   ////////////////////
   // level changes at once, with no wait for a clock edge; a reset is a fall then a rise
   task automatic set_pin(input logic v);
      drv <= v;
   endtask
   // the device wins while it drives
   assign pin_in = pin_oe ? pin_out : drv;
endmodule // pin_host_model

// file: tb/tb_gpio_function_control.sv
/* testbench of the pin function block: registers, pin output, actions
   assumes the design files, the checker and the host pin model */
`timescale 1ns/10ps
module tb_gpio_function_control;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, pm_wr = 1'b0, pm_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, pm_page = 8'hFF, pm_cmd = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, q;
   logic [5:0] st = 6'h20; // {slew_done, wc1, wc0, ch1, ch0, mem}
   logic pin_in, pin_out, pin_oe, fault_dump, output_clear, device_reset, nvm_write_allow, map_locked;
   logic shutdown_load_stored, shutdown_slew_low, shutdown_slew_high, shutdown_hiz, low_power_select, shutdown_flag;
   logic [1:0] current_output_down, voltage_output_down, synchronous_load, wave_run, margin_high;
   logic [1:0] cur, vlt, wav, mar; // expected channel states
   logic clr, rst, nvm, lck, flg; // expected global states
   int num_errors = 0, n_checks = 0, n_dump = 0, n_load = 0, e_dump = 0, e_load = 0;
   gpio_function_control #(.FILTER_CYCLES(2)) u_gpio_function_control (.ref_clk, .resetn, .reg_wr,
      .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pm_wr, .pm_rd, .pm_page, .pm_cmd, .pin_in, .pin_out,
      .pin_oe, .memory_write_pending(st[0]), .ch0_busy(st[1]), .ch1_busy(st[2]), .window_compare_ch0(st[3]),
      .window_compare_ch1(st[4]), .slew_done(st[5]), .fault_dump, .output_clear, .device_reset,
      .nvm_write_allow, .map_locked, .current_output_down, .voltage_output_down, .synchronous_load,
      .wave_run, .margin_high, .shutdown_load_stored, .shutdown_slew_low, .shutdown_slew_high,
      .shutdown_hiz, .low_power_select, .shutdown_flag);
   pin_host_model u_pin_host_model (.pin_out, .pin_oe, .pin_in);
   ////////////////////
   // clock and pulse counters
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (fault_dump === 1'b1) n_dump++;
      if (synchronous_load[1] === 1'b1) n_load++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one write on the register port or the power bus
   task automatic wr(input logic pm, input logic [7:0] a, input logic [15:0] d);
      reg_wr <= !pm;
      pm_wr <= pm;
      reg_addr <= a;
      pm_cmd <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      pm_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   // one read, then compare
   task automatic rc(input logic pm, input logic [7:0] a, input logic [15:0] exp);
      reg_rd <= !pm;
      pm_rd <= pm;
      reg_addr <= a;
      pm_cmd <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      pm_rd <= 1'b0;
      #1 q = reg_rdata;
      @(posedge ref_clk);
      chk(q, exp);
   endtask
   // move the pin, update expectations for function c, compare
   task automatic pin_edge(input logic [3:0] c, input logic v);
      u_pin_host_model.set_pin(v);
      repeat (12) @(posedge ref_clk);
      #1;
      case (c)
         4'h2: e_dump += !v;
         4'h3: cur = v ? 2'b00 : 2'b10;
         4'h4: vlt = v ? 2'b00 : 2'b10;
         4'h5: flg |= !v;
         4'h7: clr = !v;
         4'h8: e_load += !v;
         4'h9: wav = v ? 2'b10 : 2'b00;
         4'hA: mar = v ? 2'b10 : 2'b00;
         4'hB: rst = !v;
         4'hC: nvm = !v;
         4'hD: lck = v;
         default: ;
      endcase
      chk({output_clear, device_reset, nvm_write_allow, map_locked, shutdown_flag, current_output_down,
         voltage_output_down, wave_run, margin_high}, {clr, rst, nvm, lck, flg, cur, vlt, wav, mar});
      chk({n_dump[7:0], n_load[7:0]}, {e_dump[7:0], e_load[7:0]});
   endtask
   task automatic t_regs;
      rc(0, 8'h23, 16'h0000);
      rc(0, 8'h24, 16'h0000);
      rc(0, 8'h25, 16'h0000);
      rc(0, 8'h30, 16'h0000);
      wr(1, 8'hE9, 16'h2300);
      rc(0, 8'h25, 16'h2300);
      chk(low_power_select, 1'b1);
      pm_page <= 8'hFE;
      wr(1, 8'hE9, 16'h0000);
      pm_page <= 8'hFF;
      rc(1, 8'hE9, 16'h2300);
      wr(0, 8'h25, 16'h0000);
      rc(0, 8'h25, 16'h0000);
      $display("register test done");
   endtask
   task automatic t_output;
      logic [3:0] src [5] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'hB};
      int idx [5] = '{0, 2, 1, 4, 3};
      for (int i = 0; i < 5; i++) begin
         wr(0, 8'h24, {3'b001, src[i], 9'h000});
         for (int b = 0; b < 2; b++) begin
            st <= b[0] ? (6'h20 | (6'h01 << idx[i])) : ~(6'h01 << idx[i]);
            repeat (3) @(posedge ref_clk);
            #1;
            chk({pin_oe, pin_out}, {1'b1, b[0]});
         end
      end
      st <= 6'h38;
      wr(0, 8'h24, 16'h0000);
      rc(0, 8'h23, 16'h0090);
      chk(pin_oe, 1'b0);
      st <= 6'h20;
      $display("output test done");
   endtask
   task automatic t_actions;
      logic [4:0] ent [12] = '{5'h05, 5'h04, 5'h07, 5'h09, 5'h0B, 5'h0D, 5'h0F, 5'h11, 5'h13, 5'h15,
         5'h17, 5'h19};
      {cur, vlt, wav, mar, clr, rst, nvm, lck, flg} = '0;
      foreach (ent[i]) begin
         wr(0, 8'h24, {7'h40, 4'b0001, ent[i]});
         pin_edge(ent[i][0] ? ent[i][4:1] : 4'h0, 1'b0);
         pin_edge(ent[i][0] ? ent[i][4:1] : 4'h0, 1'b1);
      end
      chk(shutdown_hiz, 1'b1);
      rc(0, 8'h23, 16'h0100);
      rc(0, 8'h23, 16'h0000);
      flg = 1'b0;
      $display("action test done");
   endtask
   task automatic t_lock;
      wr(0, 8'h24, 16'h803B);
      pin_edge(4'hD, 1'b0);
      pin_edge(4'hD, 1'b1);
      wr(1, 8'hE8, 16'h0000);
      rc(0, 8'h24, 16'h803B);
      pin_edge(4'hD, 1'b0);
      wr(0, 8'h24, 16'h0000);
      rc(0, 8'h24, 16'h0000);
      $display("lock test done");
   endtask
   task automatic t_shutdown;
      pin_edge(4'h0, 1'b1);
      wr(0, 8'h25, 16'h0200);
      wr(0, 8'h24, 16'h002B);
      st <= 6'h00;
      pin_edge(4'h5, 1'b0);
      pin_edge(4'h5, 1'b1);
      pin_edge(4'h5, 1'b0);
      chk({shutdown_load_stored, shutdown_slew_low, shutdown_slew_high, shutdown_hiz}, 4'h4);
      st <= 6'h20;
      repeat (2) @(posedge ref_clk);
      #1 chk({shutdown_slew_low, shutdown_hiz}, 2'h1);
      $display("shutdown test done");
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_output;
      t_actions;
      t_lock;
      t_shutdown;
      print_verdict;
   end
   // watchdog: far beyond the few hundred cycles the tests need
   initial begin
      #(100 * 5000);
      num_errors++;
      print_verdict;
   end
endmodule // tb_gpio_function_control
bind gpio_function_control gpio_function_control_asserts #(.CHANNELS(CHANNELS)) u_gpio_function_control_asserts (
   .ref_clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pm_wr, .pm_page, .pm_cmd,
   .pin_in, .pin_out, .pin_oe, .memory_write_pending, .ch0_busy, .ch1_busy, .window_compare_ch0,
   .window_compare_ch1, .fault_dump, .output_clear, .map_locked, .synchronous_load);
